/* scc_cfg.svh */
// Constants for the sensor control command register block
// Assumes inclusion by the package and the register block only
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_CTRL_ADDR 8'h08
`define SCC_TURNS_ADDR 8'h02
`define SCC_ERR_ADDR 8'h04
`define SCC_BIT_ERRCLR 0
`define SCC_BIT_SLEEP 1
`define SCC_BIT_SPEED 2
`define SCC_BIT_TURNCLR 3
`define SCC_BIT_STLAUNCH 4
`define SCC_CTRL_RESET 8'h00
`define SCC_ERR_RESET 8'h01
`define SCC_CLK_HZ 10000000
`define SCC_LOGIC_ST_MS 10
`define SCC_SIGPATH_ST_MS 40
`define SCC_LOGIC_ST_CYC ((`SCC_CLK_HZ / 1000) * `SCC_LOGIC_ST_MS)
`define SCC_SIGPATH_ST_CYC ((`SCC_CLK_HZ / 1000) * `SCC_SIGPATH_ST_MS)
`endif

/* scc_pkg.sv */
// Types for the sensor control command register block
// Assumes scc_cfg.svh is on the include path
`include "scc_cfg.svh"
package scc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_LOGIC, ST_SIGPATH} scc_st_t;
endpackage : scc_pkg

/* scc_ctrl.sv */
// Control command register with self-test sequencer and angle offset
// Assumes a serial framer delivering one-cycle write and read strobes
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module scc_ctrl #(
  parameter int ANG_W = 12,
  parameter int ERR_W = 7,
  parameter int LOGIC_CYC = `SCC_LOGIC_ST_CYC,
  parameter int SIGPATH_CYC = `SCC_SIGPATH_ST_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_selftest_choice_field,
  input wire logic i_speed_mode_default,
  input wire logic [ERR_W-1:0] i_err_set,
  input wire logic [ANG_W-1:0] i_raw_angle,
  input wire logic [ANG_W-1:0] i_ref_angle,
  output logic [ERR_W-1:0] o_err_flags,
  output logic o_turn_count_clear,
  output logic o_logic_selftest,
  output logic o_sigpath_selftest,
  output logic o_angle_blocked,
  output logic o_avg_allowed,
  output logic o_sleep_kind_select,
  output logic o_speed_mode,
  output logic [ANG_W-1:0] o_angle
);
  scc_pkg::scc_st_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic sleep_q, speed_q, boot_q, sigpend_q, sigpend_d;
  logic [ERR_W-1:0] err_q;
  logic [ANG_W-1:0] angle_q;
  logic [1:0] choice_q;

  // Write decode for the control register
  wire ctrl_wr = i_wr && (i_addr == `SCC_CTRL_ADDR);
  wire st_launch = ctrl_wr && i_wdata[`SCC_BIT_STLAUNCH];
  wire err_clr = ctrl_wr && i_wdata[`SCC_BIT_ERRCLR];
  wire [7:0] ctrl_rd = {5'h00, speed_q, sleep_q, 1'b0};

  // Turn-clear pulses for one cycle only, nothing stored; other outputs follow registered state
  assign o_turn_count_clear = ctrl_wr && i_wdata[`SCC_BIT_TURNCLR];
  assign o_logic_selftest = (st_q == scc_pkg::ST_LOGIC);
  assign o_sigpath_selftest = (st_q == scc_pkg::ST_SIGPATH);
  assign o_angle_blocked = (st_q != scc_pkg::ST_IDLE);
  assign o_avg_allowed = speed_q;
  assign o_speed_mode = speed_q;
  assign o_sleep_kind_select = sleep_q;
  assign o_err_flags = err_q;
  assign o_angle = angle_q;

  // Config bits; speed default caught on first clock after reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_q <= 1'b0;
      speed_q <= 1'b0;
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        speed_q <= i_speed_mode_default;
      end else if (ctrl_wr) begin
        speed_q <= i_wdata[`SCC_BIT_SPEED];
      end
      if (ctrl_wr) begin
        sleep_q <= i_wdata[`SCC_BIT_SLEEP];
      end
    end
  end

  // Sticky error flags, new events win over the clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      err_q <= ERR_W'(`SCC_ERR_RESET);
    end else begin
      err_q <= (err_clr ? '0 : err_q) | i_err_set;
    end
  end

  // Output angle minus reference, wraps modulo a turn
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      angle_q <= '0;
    end else if (st_q == scc_pkg::ST_IDLE) begin
      angle_q <= i_raw_angle - i_ref_angle;
    end
  end

  // Read data register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `SCC_CTRL_ADDR: o_rdata <= ctrl_rd;
        `SCC_ERR_ADDR: o_rdata <= 8'(err_q);
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Self-test sequencer: bit0 of choice logic test, bit1 signal path test
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sigpend_d = sigpend_q;
    case (st_q)
      scc_pkg::ST_IDLE: begin
        if (st_launch && choice_q[0]) begin
          st_d = scc_pkg::ST_LOGIC;
          cnt_d = 32'(LOGIC_CYC - 1);
          sigpend_d = choice_q[1];
        end else if (st_launch && choice_q[1]) begin
          st_d = scc_pkg::ST_SIGPATH;
          cnt_d = 32'(SIGPATH_CYC - 1);
          sigpend_d = 1'b0;
        end
      end
      scc_pkg::ST_LOGIC: begin
        if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else if (sigpend_q) begin
          st_d = scc_pkg::ST_SIGPATH;
          cnt_d = 32'(SIGPATH_CYC - 1);
          sigpend_d = 1'b0;
        end else begin
          st_d = scc_pkg::ST_IDLE;
        end
      end
      scc_pkg::ST_SIGPATH: begin
        if (cnt_q != 32'h0) begin
          cnt_d = cnt_q - 32'h1;
        end else begin
          st_d = scc_pkg::ST_IDLE;
        end
      end
      default: st_d = scc_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state; choice field sampled each cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= scc_pkg::ST_IDLE;
      cnt_q <= 32'h0;
      sigpend_q <= 1'b0;
      choice_q <= 2'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sigpend_q <= sigpend_d;
      choice_q <= i_selftest_choice_field;
    end
  end

  // Assertions
  AST_CMD_READS_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == `SCC_CTRL_ADDR) |=> (o_rdata[7:3] == 5'h00 && o_rdata[0] == 1'b0))
    else $error("command bits read nonzero");
  AST_UNUSED_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == `SCC_CTRL_ADDR) |=> o_rdata[7:5] == 3'h0)
    else $error("unused bits nonzero");
  AST_TURN_PULSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_turn_count_clear |->
      (i_wr && i_addr == `SCC_CTRL_ADDR && i_wdata[`SCC_BIT_TURNCLR])
      ##1 (!o_turn_count_clear || i_wr))
    else $error("turn clear not tied to write");
  AST_ERR_CLEAR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (err_clr && i_err_set == '0) |=> o_err_flags == '0)
    else $error("error flags not cleared");
  AST_ERR_STICKY: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!err_clr) |=> ((o_err_flags & $past(o_err_flags)) == $past(o_err_flags)))
    else $error("error flag dropped");
  AST_SPEED_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_wr && !boot_q) |=> o_speed_mode == $past(i_wdata[2]))
    else $error("speed override not taken");
  AST_SPEED_BOOT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (boot_q && i_resetn) |=> o_speed_mode == $past(i_speed_mode_default))
    else $error("speed default not loaded");
  AST_AVG: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_avg_allowed == o_speed_mode)
    else $error("averaging gate wrong");
  // Averaging gate must match the speed bit that software reads back
  AST_AVG_READBACK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == `SCC_CTRL_ADDR) |=> o_rdata[`SCC_BIT_SPEED] == $past(o_avg_allowed))
    else $error("averaging gate differs from speed bit");
  AST_LAUNCH: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st_q == scc_pkg::ST_IDLE && st_launch && choice_q != 2'h0) |=> o_angle_blocked)
    else $error("self-test not launched");
  AST_BLOCK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_angle_blocked |=> $stable(o_angle))
    else $error("angle changed during self-test");
  AST_ANGLE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_resetn && st_q == scc_pkg::ST_IDLE) |=>
      o_angle == $past(i_raw_angle) - $past(i_ref_angle))
    else $error("output angle wrong");
  COV_LOGIC: cover property (@(posedge i_clk) disable iff (!i_resetn) o_logic_selftest);
  COV_SIGPATH: cover property (@(posedge i_clk) disable iff (!i_resetn) o_sigpath_selftest);
  COV_ERRCLR: cover property (@(posedge i_clk) disable iff (!i_resetn) err_clr);
endmodule : scc_ctrl
`default_nettype wire

/* scc_host.sv */
// Host model driving the control register strobes
// Assumes callers run on the i_clk domain
`timescale 1ns/1ps
`default_nettype none
module scc_host (
  input wire logic i_clk,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // One strobe cycle, then lines flip so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= ~w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : xfer
endmodule : scc_host
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the control command register
// Assumes scc_ctrl with short self-test counts of 8 and 20 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [1:0] choice = 2'h0;
  logic spd_def = 1'b1;
  logic [6:0] err_set = 7'h00;
  logic [11:0] raw = 12'h000;
  logic [11:0] ref_a = 12'h000;
  logic [11:0] angle, a0, ra, rf;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] err, ev;
  logic wr, rd, tcc, lst, sst, blk, avg, slp, spd;
  logic rd_d1 = 1'b0;
  logic [7:0] expq[$];
  int miscompares = 0;
  int checks = 0;
  int tc_cnt = 0;
  int seed, k, nl, ns, nb;
  scc_host h (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  scc_ctrl #(.ANG_W(12), .ERR_W(7), .LOGIC_CYC(8), .SIGPATH_CYC(20)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .i_selftest_choice_field(choice),
    .i_speed_mode_default(spd_def), .i_err_set(err_set), .i_raw_angle(raw),
    .i_ref_angle(ref_a), .o_err_flags(err), .o_turn_count_clear(tcc),
    .o_logic_selftest(lst), .o_sigpath_selftest(sst), .o_angle_blocked(blk),
    .o_avg_allowed(avg), .o_sleep_kind_select(slp), .o_speed_mode(spd), .o_angle(angle));
  // Clock at 100 ns
  initial forever #50 i_clk = ~i_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Read with its expected value queued for the watcher
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    h.xfer(1'b0, a, 8'h00);
  endtask : rd_chk
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask : step
  task automatic do_reset();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask : do_reset
  // Watcher: read data one cycle after the strobe, turn-clear pulses
  always @(posedge i_clk) begin
    if (rd_d1 === 1'b1) cmp(rdata, expq.pop_front());
    rd_d1 <= rd;
    if (tcc === 1'b1) tc_cnt++;
  end
  // Watchdog
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    seed = 32'ha051;
    do_reset();
    rd_chk(8'h08, 8'h04);
    step();
    cmp(err, 7'h01);
    h.xfer(1'b1, 8'h08, 8'h05);
    step();
    cmp({err, avg}, 8'h01);
    @(posedge i_clk);
    ev = 7'($random(seed)) | 7'h02;
    err_set <= ev;
    @(posedge i_clk);
    err_set <= 7'h00;
    step();
    step();
    cmp(err, ev);
    h.xfer(1'b1, 8'h08, 8'he3);
    step();
    cmp(err, 7'h00);
    rd_chk(8'h08, 8'h02);
    step();
    cmp({slp, spd, avg}, 3'b100);
    k = tc_cnt;
    h.xfer(1'b1, 8'h08, 8'h0a);
    rd_chk(8'h08, 8'h02);
    rd_chk(8'h33, 8'h00);
    cmp(tc_cnt - k, 1);
    for (k = 0; k < 4; k++) begin
      @(posedge i_clk);
      choice <= k[1:0];
      h.xfer(1'b1, 8'h08, 8'h10);
      a0 = angle;
      raw <= raw + 12'h123;
      nl = 0;
      ns = 0;
      nb = 0;
      repeat (40) begin
        #1;
        nl += lst;
        ns += sst;
        nb += blk;
        if (blk !== 1'b0) cmp(angle, a0);
        @(posedge i_clk);
      end
      cmp(nl, 8 * k[0]);
      cmp(ns, 20 * k[1]);
      cmp(nb, 8 * k[0] + 20 * k[1]);
    end
    ra = 12'($random(seed));
    rf = 12'($random(seed));
    raw <= ra;
    ref_a <= rf;
    step();
    step();
    cmp(angle, 12'(ra - rf));
    @(posedge i_clk);
    ref_a <= 12'h000;
    step();
    step();
    a0 = angle;
    @(posedge i_clk);
    ref_a <= a0;
    step();
    step();
    cmp(angle, 12'h000);
    h.xfer(1'b1, 8'h08, 8'h04);
    step();
    cmp({spd, avg}, 2'b11);
    @(posedge i_clk);
    spd_def <= 1'b0;
    do_reset();
    rd_chk(8'h08, 8'h00);
    step();
    step();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
